// ===== hdl/lrsr_top.sv
/*
 * Refresh and self refresh logic inside the DRAM device. It decodes refresh
 * and self refresh entry from the command pins, keeps a per-bank refresh
 * round robin and runs an internal refresh timer while in self refresh.
 * Assumes the command pins and memory clock come from another domain and are
 * sampled by the 20 MHz block clock through two flip-flops.
 */
// Notes on behaviour
// - Other banks stay usable during per-bank refresh.
// - Entry is CKE low, CS low, CA=100.
// - Internal timer refreshes, internal clock off.
// - In self refresh only CKE matters.
// - One internal refresh within least residency.
`timescale 1ns/1ns
module lrsr_top
  import lrsr_pkg::*;
(
  input  wire logic                        I_CLK,
  input  wire logic                        I_RESET,
  input  wire logic                        I_MEM_CLK,
  input  wire logic                        I_CKE,
  input  wire logic                        I_CS_N,
  input  wire logic [3:0]                  I_CA,
  input  wire logic [lrsr_pkg::NUM_BANKS-1:0] I_BANK_OPEN,
  output logic                             O_IN_SELF_REFRESH,
  output logic                             O_INT_CLK_EN,
  output logic                             O_REFRESH_PULSE,
  output logic                             O_ALL_BANK,
  output logic [lrsr_pkg::BANK_W-1:0]      O_REFRESH_BANK,
  output logic [lrsr_pkg::NUM_BANKS-1:0]   O_BANK_BUSY,
  output logic [lrsr_pkg::CNT_W-1:0]       O_REFRESH_COUNT
);
  import lrsr_pkg::*;

  // ****************************************************************
  // Input synchronisers: two flops each, first stage read by nobody else.
  // ****************************************************************
  logic [7:0] meta_q;                                     // First stage.
  logic [7:0] sync_q;                                     // Second stage.
  logic       mclk_prev_q;                                // Memory clock one sample ago.

  // Synchronise memory clock, CKE, chip select and command bits.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= {1'b0, I_MEM_CLK, I_CKE, I_CS_N, I_CA};
      sync_q <= meta_q;
    end
  end

  wire       mclk_s = sync_q[6];                          // Synchronised memory clock.
  wire       cke_s  = sync_q[5];                          // Synchronised clock enable.
  wire       cs_n_s = sync_q[4];                          // Synchronised chip select.
  wire [3:0] ca_s   = sync_q[3:0];                        // Synchronised command bits.

  logic [NUM_BANKS-1:0] open_meta_q;                      // Bank status, first stage.
  logic [NUM_BANKS-1:0] open_sync_q;                      // Bank status, second stage.

  // Bank status only feeds coverage of refreshes beside open banks; the device
  // itself never needs it, since the controller keeps the idle-bank rules.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      open_meta_q <= '0;
      open_sync_q <= '0;
    end else begin
      open_meta_q <= I_BANK_OPEN;
      open_sync_q <= open_meta_q;
    end
  end

  // Remember memory clock for edge detection.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= mclk_s;
    end
  end

  // ****************************************************************
  // Command decode on memory clock rising edges.
  // ****************************************************************
  wire  mclk_rise = mclk_s && !mclk_prev_q;               // One-cycle edge pulse.
  logic cke_prev_q;                                       // CKE at the previous edge.

  // Refresh-family code is shared by refresh and self refresh entry.
  function automatic logic is_ref_code(input logic cs_n, input logic [3:0] ca);
    return !cs_n && (ca[2:0] == CA_REFRESH);
  endfunction

  // CKE value seen at the previous memory clock edge.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      cke_prev_q <= 1'b1;
    end else if (mclk_rise) begin
      cke_prev_q <= cke_s;
    end
  end

  lrsr_state_t state_q;                                   // Controller state.

  // Self refresh entry needs CKE high before and low now.
  wire sr_entry = mclk_rise && (state_q == LRSR_ACTIVE) && cke_prev_q && !cke_s
                  && is_ref_code(cs_n_s, ca_s);
  // External refresh only in normal operation with CKE high.
  wire ext_ref  = mclk_rise && (state_q == LRSR_ACTIVE) && cke_prev_q && cke_s
                  && is_ref_code(cs_n_s, ca_s);
  wire ext_all  = ext_ref && ca_s[3];                     // All-bank form.
  wire ext_one  = ext_ref && !ca_s[3];                    // Single-bank form.

  // ****************************************************************
  // Self refresh state machine and internal timer.
  // ****************************************************************
  localparam logic [TMR_W-1:0] RESID_CYC = TMR_W'(MIN_SR_RESIDENCY_CYC);   // Least stay.
  localparam logic [TMR_W-1:0] INT_CYC   = TMR_W'(AVG_REFRESH_INTERVAL_CYC);// Timer period.

  logic [TMR_W-1:0] sr_tmr_q;                             // Cycles since entry / last refresh.
  logic [TMR_W-1:0] resid_q;                              // Cycles in self refresh.
  logic             int_ref;                              // Internal refresh this cycle.

  // While in self refresh only CKE is watched; other pins are ignored.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state_q <= LRSR_ACTIVE;
    end else begin
      unique case (state_q)
        LRSR_ACTIVE: begin
          if (sr_entry) begin
            state_q <= LRSR_SR;
          end
        end
        LRSR_SR: begin
          // Exit is honoured only once the least residency has passed.
          if (cke_s && (resid_q >= RESID_CYC)) begin
            state_q <= LRSR_EXIT;
          end
        end
        LRSR_EXIT: begin
          state_q <= LRSR_ACTIVE;
        end
      endcase
    end
  end

  // First internal refresh fires at entry+1 so it lands inside the least stay.
  assign int_ref = (state_q == LRSR_SR) && (sr_tmr_q == TMR_ZERO);

  // Internal refresh timer: runs from the block clock, not the memory clock.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      sr_tmr_q <= TMR_ZERO;
    end else if (state_q != LRSR_SR) begin
      sr_tmr_q <= TMR_ZERO;
    end else if (sr_tmr_q >= INT_CYC - TMR_ONE) begin
      sr_tmr_q <= TMR_ZERO;
    end else begin
      sr_tmr_q <= sr_tmr_q + TMR_ONE;
    end
  end

  // Residency counter saturates once the least stay is met.
  always_ff @(posedge I_CLK) begin
    if (I_RESET || state_q != LRSR_SR) begin
      resid_q <= TMR_ZERO;
    end else if (resid_q < RESID_CYC) begin
      resid_q <= resid_q + TMR_ONE;
    end
  end

  // ****************************************************************
  // Refresh execution, bank round robin and outputs.
  // ****************************************************************
  logic [BANK_W-1:0]    bank_ptr_q;                       // Next single-bank target.
  logic [NUM_BANKS-1:0] busy;                             // Banks under refresh.

  // Round robin counter; all-bank refresh and self refresh exit reset it.
  always_ff @(posedge I_CLK) begin
    if (I_RESET || ext_all || state_q == LRSR_EXIT) begin
      bank_ptr_q <= BANK_ZERO;
    end else if (ext_one) begin
      bank_ptr_q <= bank_ptr_q + BANK_ONE;
    end
  end

  // Only the target bank goes busy; others stay usable.
  lrsr_bank_busy u_busy (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_start (ext_one),
    .i_bank  (bank_ptr_q),
    .o_busy  (busy)
  );

  // Registered outputs describing each refresh performed.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_REFRESH_PULSE   <= 1'b0;
      O_ALL_BANK        <= 1'b0;
      O_REFRESH_BANK    <= BANK_ZERO;
      O_IN_SELF_REFRESH <= 1'b0;
      O_INT_CLK_EN      <= 1'b1;
      O_BANK_BUSY       <= '0;
    end else begin
      O_REFRESH_PULSE   <= ext_ref || int_ref;
      O_ALL_BANK        <= ext_all || int_ref;
      O_REFRESH_BANK    <= ext_one ? bank_ptr_q : BANK_ZERO;
      O_IN_SELF_REFRESH <= (state_q == LRSR_SR);
      // Internal clock stops for the whole self refresh stay.
      O_INT_CLK_EN      <= (state_q != LRSR_SR) && !sr_entry;
      O_BANK_BUSY       <= busy;
    end
  end

  // Count of all refreshes performed, external and internal.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_REFRESH_COUNT <= CNT_ZERO;
    end else if (ext_ref || int_ref) begin
      O_REFRESH_COUNT <= O_REFRESH_COUNT + CNT_ONE;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // Entry leads to self refresh one cycle later.
  sr_entry_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    sr_entry |=> state_q == LRSR_SR)
    else $error("Self refresh entry not taken.");
  // Internal clock off in self refresh.
  clk_off_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    state_q == LRSR_SR |=> !O_INT_CLK_EN)
    else $error("Internal clock running in self refresh.");
  // An internal refresh appears within the least stay.
  int_ref_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    sr_entry |-> ##[1:3] O_REFRESH_PULSE && O_ALL_BANK)
    else $error("No internal refresh after entry.");
  // Pins other than CKE do not create refreshes in self refresh.
  ignore_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_q == LRSR_SR) && !int_ref |=> !O_REFRESH_PULSE)
    else $error("External command taken in self refresh.");
  // Single-bank refresh marks only its bank busy.
  bank_busy_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    ext_one |=> ##1 O_BANK_BUSY == (NUM_BANKS'(1) << $past(bank_ptr_q, 2)))
    else $error("Wrong bank marked busy.");
  // Exit returns to normal operation next cycle.
  exit_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    state_q == LRSR_EXIT |=> state_q == LRSR_ACTIVE)
    else $error("Exit did not complete.");
  // Counter steps on each refresh.
  count_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (ext_ref || int_ref) |=> O_REFRESH_COUNT == $past(O_REFRESH_COUNT) + CNT_ONE)
    else $error("Refresh count did not step.");
  // Round robin resets on all-bank refresh.
  rr_reset_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    ext_all |=> bank_ptr_q == BANK_ZERO)
    else $error("Bank pointer not cleared.");

  sr_seen_c:  cover property (@(posedge I_CLK) disable iff (I_RESET) sr_entry);
  exit_c:     cover property (@(posedge I_CLK) disable iff (I_RESET) state_q == LRSR_EXIT);
  one_ref_c:  cover property (@(posedge I_CLK) disable iff (I_RESET) ext_one);
  all_ref_c:  cover property (@(posedge I_CLK) disable iff (I_RESET) ext_all);
  open_ref_c: cover property (@(posedge I_CLK) disable iff (I_RESET) ext_one && |open_sync_q);

endmodule // lrsr_top

// ===== hdl/lrsr_pkg.sv
/*
 * Package for the DRAM refresh and self refresh block: command codes, timing
 * figures and derived cycle counts at the 20 MHz block clock.
 * Assumes one clock domain and a synchronous active-high reset.
 */
package lrsr_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS             = 50;         // Block clock period.
  localparam int unsigned MIN_SR_RESIDENCY_NS       = 15;         // Least self refresh residency.
  localparam int unsigned MIN_SR_RESIDENCY_CYC_RAW  =
    (MIN_SR_RESIDENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // Rounded up.
  localparam int unsigned MIN_SR_RESIDENCY_CYC      =
    (MIN_SR_RESIDENCY_CYC_RAW < 1) ? 1 : MIN_SR_RESIDENCY_CYC_RAW;
  localparam int unsigned AVG_REFRESH_INTERVAL_NS   = 7800;       // Internal timer interval.
  localparam int unsigned AVG_REFRESH_INTERVAL_CYC  =
    AVG_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;                      // Rounded down.
  localparam int unsigned SINGLE_BANK_REFRESH_CYCLE_NS = 60;     // Per-bank refresh busy time.
  localparam int unsigned SINGLE_BANK_REFRESH_CYCLE_CYC =
    (SINGLE_BANK_REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Widths and counts.
  // ****************************************************************
  localparam int unsigned NUM_BANKS  = 8;                 // Banks in the round robin.
  localparam int unsigned BANK_W     = 3;                 // Bank index width.
  localparam int unsigned TMR_W      = 16;                // Timer width.
  localparam int unsigned CNT_W      = 16;                // Refresh counter width.

  localparam logic [TMR_W-1:0] TMR_ZERO   = 16'h0000;     // Timer reset value.
  localparam logic [TMR_W-1:0] TMR_ONE    = 16'h0001;     // Timer step.
  localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;         // Bank counter reset value.
  localparam logic [BANK_W-1:0] BANK_ONE  = 3'h1;         // Bank counter step.
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;     // Counter reset value.
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;     // Counter step.

  // ****************************************************************
  // Command decode codes (chip select, CA0, CA1, CA2, CA3).
  // ****************************************************************
  localparam logic [2:0] CA_REFRESH = 3'h4;               // CA2 high, CA1 low, CA0 low.

  // ****************************************************************
  // Controller states.
  // ****************************************************************
  typedef enum logic [2:0] {
    LRSR_ACTIVE  = 3'b001,                                // Normal operation.
    LRSR_SR      = 3'b010,                                // In self refresh.
    LRSR_EXIT    = 3'b100                                 // Leaving self refresh.
  } lrsr_state_t;

endpackage : lrsr_pkg

// ===== hdl/lrsr_bank_busy.sv
/*
 * Per-bank busy tracker: one countdown per bank that runs while that bank is
 * being refreshed. Assumes a start pulse on the block clock.
 */
`timescale 1ns/1ns
module lrsr_bank_busy
  import lrsr_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_start,
  input  wire logic [BANK_W-1:0]    i_bank,
  output logic      [NUM_BANKS-1:0] o_busy
);

  // ****************************************************************
  // One small countdown per bank.
  // ****************************************************************
  localparam logic [TMR_W-1:0] BUSY_CYC = TMR_W'(SINGLE_BANK_REFRESH_CYCLE_CYC); // Busy length.

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
      logic [TMR_W-1:0] left_q;                            // Cycles still busy.
      // Load on a refresh of this bank, else count down to zero.
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          left_q <= TMR_ZERO;
        end else if (i_start && (i_bank == BANK_W'(g))) begin
          left_q <= BUSY_CYC;
        end else if (left_q != TMR_ZERO) begin
          left_q <= left_q - TMR_ONE;
        end
      end
      // Busy flag comes from a register as well.
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          o_busy[g] <= 1'b0;
        end else begin
          o_busy[g] <= (i_start && (i_bank == BANK_W'(g))) || (left_q > TMR_ONE);
        end
      end
    end
  endgenerate

endmodule // lrsr_bank_busy

// ===== verif/lrsr_host_model.sv
/*
 * Behavioural memory controller facing the refresh block: it makes the
 * memory clock and drives clock enable, chip select and the command bits.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
`timescale 1ns/1ns
module lrsr_host_model (
  output logic       o_mem_clk,
  output logic       o_cke,
  output logic       o_cs_n,
  output logic [3:0] o_ca,
  output logic [7:0] o_bank_open
);
  // ****************************************************************
  // Idle levels.
  // ****************************************************************
  // Banks are idle unless the bench opens one beside single-bank refreshes of others.
  // No activates are sent, so activate spacing is met trivially.
  // The run is far shorter than one refresh window, so window totals, self refresh
  // credit and their tracking are met without counting.
  initial begin
    o_mem_clk   = 1'b0;
    o_cke       = 1'b1;
    o_cs_n      = 1'b1;
    o_ca        = 4'h0;
    o_bank_open = 8'h00;  // All banks idle.
  end

  // ****************************************************************
  // Command cycles.
  // ****************************************************************
  // One 400 ns memory clock cycle; the clock stands still between calls.
  // Pins change half a cycle before the rising edge, so they are settled there.
  task tick(input logic cs_n, input logic [3:0] ca, input logic cke);
    o_cs_n = cs_n;
    o_ca   = cs_n ? ~o_ca : ca;  // Deselected lines keep changing.
    o_cke  = cke;
    #200;
    o_mem_clk = 1'b1;
    #200;
    o_mem_clk = 1'b0;
  endtask

  // Marks which banks hold an open row; a targeted bank is never marked.
  task set_open(input logic [7:0] m);
    o_bank_open = m;
  endtask

  // Self refresh entry with the cycles that must surround it.
  task enter_sr();
    tick(1'b1, 4'h0, 1'b1);  // Clock enable high the cycle before.
    tick(1'b0, 4'h4, 1'b0);  // Entry command with clock enable low.
    tick(1'b1, 4'h0, 1'b0);  // No-operation after entry, enable kept low.
  endtask

  // Self refresh exit: clock first, then enable high with only NOPs.
  task exit_sr();
    repeat (2) tick(1'b1, 4'h0, 1'b0);  // Stable clock before enable rises.
    repeat (3) tick(1'b1, 4'h0, 1'b1);  // NOPs across the exit interval.
  endtask
endmodule // lrsr_host_model

// ===== verif/tb_lrsr_top.sv
/*
 * Self-checking bench for the refresh and self refresh block.
 * Assumes the host model drives every command pin and the memory clock.
 */
`timescale 1ns/1ns
module tb_lrsr_top;
  import lrsr_pkg::*;

  // ****************************************************************
  // Signals.
  // ****************************************************************
  typedef struct packed {
    logic       cs_n;   // Chip select level.
    logic [3:0] ca;     // Command bits.
    logic       pulse;  // A refresh is expected.
    logic       all;    // All-bank refresh expected.
    logic [2:0] bank;   // Expected target bank.
  } lrsr_row_t;
  localparam lrsr_row_t ROWS [8] = '{
    {1'b0, 4'hc, 1'b1, 1'b1, 3'h0}, {1'b0, 4'h4, 1'b1, 1'b0, 3'h0},
    {1'b0, 4'h4, 1'b1, 1'b0, 3'h1}, {1'b1, 4'h4, 1'b0, 1'b0, 3'h0},
    {1'b0, 4'h5, 1'b0, 1'b0, 3'h0}, {1'b0, 4'h4, 1'b1, 1'b0, 3'h2},
    {1'b0, 4'hc, 1'b1, 1'b1, 3'h0}, {1'b0, 4'h4, 1'b1, 1'b0, 3'h0}};
  logic            clk, reset;            // Block clock and reset.
  wire             mem_clk, cke, cs_n;    // Pins from the host model.
  wire  [3:0]      ca;                    // Command bits.
  wire  [7:0]      bank_open;             // Bank status.
  logic            in_sr, clk_en, pulse, all_bank;
  logic [BANK_W-1:0]    bank;
  logic [NUM_BANKS-1:0] busy, busy_seen;  // Busy bits and their union.
  logic [CNT_W-1:0]     count, exp_cnt;   // Refresh count seen and expected.
  logic            last_all;              // Kind of the latest refresh.
  logic [2:0]      last_bank;             // Bank of the latest refresh.
  int              miscompares = 0, total_checks = 0;
  int              cyc = 0, pulses = 0, p0 = 0, last_cyc = 0, prev_cyc = 0;

  lrsr_host_model host (.o_mem_clk(mem_clk), .o_cke(cke), .o_cs_n(cs_n), .o_ca(ca),
                        .o_bank_open(bank_open));
  lrsr_top dut (.I_CLK(clk), .I_RESET(reset), .I_MEM_CLK(mem_clk), .I_CKE(cke), .I_CS_N(cs_n),
                .I_CA(ca), .I_BANK_OPEN(bank_open), .O_IN_SELF_REFRESH(in_sr),
                .O_INT_CLK_EN(clk_en), .O_REFRESH_PULSE(pulse), .O_ALL_BANK(all_bank),
                .O_REFRESH_BANK(bank), .O_BANK_BUSY(busy), .O_REFRESH_COUNT(count));

  // ****************************************************************
  // Clock, monitor and helpers.
  // ****************************************************************
  // The 50 ns block clock.
  always #25 clk = ~clk;

  // Records every refresh pulse so one-cycle outputs are never missed.
  always @(posedge clk) begin
    cyc       <= cyc + 1;
    busy_seen <= busy_seen | busy;
    if (pulse === 1'b1) begin
      pulses    <= pulses + 1;
      last_all  <= all_bank;
      last_bank <= bank;
      prev_cyc  <= last_cyc;
      last_cyc  <= cyc;
    end
  end

  // Compares with case equality so an unknown never matches.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Sends one command and lets the two-stage sampling and the answer land.
  task automatic run_cmd(input logic c, input logic [3:0] a);
    busy_seen = '0;
    p0 = pulses;
    host.tick(c, a, 1'b1);
    repeat (6) @(posedge clk);
    #5;
  endtask

  // Waits, with a bound, for the self refresh flag to reach a level.
  task automatic wait_sr(input logic lvl);
    @(posedge clk);
    for (int n = 0; n < 40 && in_sr !== lvl; n++) @(posedge clk);
    #5;
  endtask

  task print_verdict();
    $display("Checks: %0d, mismatches: %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run of a few hundred cycles.
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    busy_seen = '0;
    exp_cnt = '0;
    repeat (3) @(posedge clk);
    #5;
    check({in_sr, clk_en, pulse, all_bank, bank, busy, count}, {1'b0, 1'b1, 29'h0});
    @(posedge clk);
    #5 reset = 1'b0;
    @(posedge clk);
    #5;
    // Table of plain commands: kinds, deselect, other command, pointer reset.
    // Only two all-bank refreshes are sent, far below the burst limit.
    for (int i = 0; i < 8; i++) begin
      run_cmd(ROWS[i].cs_n, ROWS[i].ca);
      check(pulses - p0, ROWS[i].pulse);
      if (ROWS[i].pulse) begin
        check(last_all, ROWS[i].all);
        check(last_bank, ROWS[i].bank);
        if (!ROWS[i].all) check(busy_seen, 8'h01 << ROWS[i].bank);
      end
      exp_cnt = exp_cnt + ROWS[i].pulse;
      check(count, exp_cnt);
    end
    // Entry, internal refresh, ignored pins, then the internal interval.
    p0 = pulses;
    host.enter_sr();
    wait_sr(1'b1);
    repeat (4) @(posedge clk);
    #5;
    check(in_sr, 1'b1);
    check(clk_en, 1'b0);
    check(pulses - p0, 1);
    check(last_all, 1'b1);
    host.tick(1'b0, 4'hc, 1'b0);
    host.tick(1'b0, 4'h4, 1'b0);
    check(pulses - p0, 1);
    check(in_sr, 1'b1);
    for (int n = 0; n < 200 && pulses - p0 < 2; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    #5;
    check(last_cyc - prev_cyc, AVG_REFRESH_INTERVAL_CYC);
    // Residency is long past before exit is asked for.
    host.exit_sr();
    wait_sr(1'b0);
    check(clk_en, 1'b1);
    exp_cnt = exp_cnt + 16'h0002;
    check(count, exp_cnt);
    // A full round and one more, back to back, after exit.
    // Bank 7 holds an open row until its own turn comes.
    host.set_open(8'h80);
    for (int b = 0; b < 9; b++) begin
      if (b == 7) host.set_open(8'h00);
      run_cmd(1'b0, 4'h4);
      check(pulses - p0, 1);
      check(last_bank, b % 8);
      check(busy_seen, 8'h01 << (b % 8));
    end
    exp_cnt = exp_cnt + 16'h0009;
    check(count, exp_cnt);
    // Second entry right after the burst, then a reset in the middle of self refresh.
    host.enter_sr();
    wait_sr(1'b1);
    check(in_sr, 1'b1);
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #5;
    check({in_sr, clk_en, pulse, all_bank, bank, busy, count}, {1'b0, 1'b1, 29'h0});
    reset = 1'b0;
    @(posedge clk);
    #5;
    // Pointer and count start afresh, and commands are taken again.
    run_cmd(1'b0, 4'h4);
    check(pulses - p0, 1);
    check(last_bank, 3'h0);
    check(count, 16'h0001);
    print_verdict();
  end
endmodule // tb_lrsr_top
